// [shared/spp_pkg.sv]
/*
 * spp_pkg: constants and carrier types for the sequential port pointer control.
 * Assumes a 40 MHz system clock and a separate sequential (link) clock.
 */
package spp_pkg;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam logic [ADDR_W-1:0] PTR_RESET = 11'h000;
    localparam logic [2:0] CMD_RELEASE_ADDR = 3'h4;
    localparam int RELEASE_BIT = 4;
    localparam logic [1:0] SYNC_RESET = 2'h0;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } spp_wr_t;

    typedef enum logic [0:0] {
        SPP_ACC_READ,
        SPP_ACC_WRITE
    } spp_acc_t;
endpackage : spp_pkg

// [rtl/spp_fifo.sv]
/*
 * spp_fifo: single-clock FIFO with valid/ready on both sides.
 * Assumes synchronous use in one clock domain.
 */
`timescale 1ns/10ps
module spp_fifo #(
    parameter int WIDTH = 19,
    parameter int DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("spp_fifo depth must be a power of two");
        end
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;

    assign o_in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign o_out_valid = wr_q != rd_q;
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = mem_q[rd_q[AW-1:0]];

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_q <= '0;
        end else if (push) begin
            wr_q <= wr_q + (AW+1)'(1);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_q <= '0;
        end else if (pop) begin
            rd_q <= rd_q + (AW+1)'(1);
        end
    end
endmodule : spp_fifo

// [rtl/spp_top.sv]
/*
 * spp_top: sequential port of a dual-port buffer: pointer load, counting,
 * clocked read/write with output enable, and stop from the controller, restart from the random port.
 * Assumes the sequential clock is free-running from the external controller;
 * random-port command writes arrive on the 40 MHz reference clock.
 */
`timescale 1ns/10ps

// Overview of operation
// - a low start strobe loads its start address into the pointer on that edge
// - count enable high holds the address counter that cycle
// - select low with read high drives data at the pointer that cycle
// - select low with read low writes data, also right after a read
// - count enable is honoured on the cycle right after a start strobe
// - write with count enable inactive rewrites the same location
// - outputs stay off while write is registered, until a read is clocked in
// - a stopped port resumes when the release bit is cleared from random side
// - release is zero on bit four at command address 100, command mode
// - command select low and chip enable high means command mode access
// - no increment on the cycle after a load strobe pointer load
module spp_top #(
    parameter int ADDR_W = spp_pkg::ADDR_W,
    parameter int DATA_W = spp_pkg::DATA_W,
    parameter int FIFO_DEPTH = spp_pkg::FIFO_DEPTH
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_seq_clk,
    input wire logic [ADDR_W-1:0] i_start_addr_one,
    input wire logic [ADDR_W-1:0] i_start_addr_two,
    input wire logic [ADDR_W-1:0] i_load_addr,
    input wire logic i_start_pointer_strobe_one_n,
    input wire logic i_start_pointer_strobe_two_n,
    input wire logic i_pointer_load_strobe_n,
    input wire logic i_count_enable_n,
    input wire logic i_sequential_chip_select_n,
    input wire logic i_sequential_read_write_select,
    input wire logic i_sequential_output_enable_n,
    input wire logic i_stop,
    input wire logic [DATA_W-1:0] i_seq_data,
    output logic [DATA_W-1:0] o_seq_data,
    output logic o_seq_data_oe,
    output logic o_stopped,
    input wire logic i_cmd_select_n,
    input wire logic i_rnd_chip_enable_n,
    input wire logic i_rnd_write,
    input wire logic [2:0] i_rnd_addr,
    input wire logic [DATA_W-1:0] i_rnd_wdata,
    output logic o_wr_ready,
    output logic o_rnd_wr_valid,
    input wire logic i_rnd_wr_ready,
    output logic [ADDR_W-1:0] o_rnd_wr_addr,
    output logic [DATA_W-1:0] o_rnd_wr_data
);
    initial begin
        // mirror words use the package struct, so widths must match it
        if (DATA_W <= spp_pkg::RELEASE_BIT || ADDR_W < 1 || FIFO_DEPTH < 2
                || ADDR_W != spp_pkg::ADDR_W || DATA_W != spp_pkg::DATA_W) begin
            $error("spp_top parameters out of range");
        end
    end

    // reset release, per domain
    logic [1:0] rst_ref_q;
    logic [1:0] rst_seq_q;
    logic rst_ref_n;
    logic rst_seq_n;
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_ref_q <= spp_pkg::SYNC_RESET;
        end else begin
            rst_ref_q <= {rst_ref_q[0], 1'b1};
        end
    end
    always_ff @(posedge i_seq_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_seq_q <= spp_pkg::SYNC_RESET;
        end else begin
            rst_seq_q <= {rst_seq_q[0], 1'b1};
        end
    end
    assign rst_ref_n = rst_ref_q[1];
    assign rst_seq_n = rst_seq_q[1];

    // random side: counter release command, sent as a toggle
    logic release_cmd;
    logic release_tgl_q;
    assign release_cmd = !i_cmd_select_n && i_rnd_chip_enable_n && i_rnd_write
        && i_rnd_addr == spp_pkg::CMD_RELEASE_ADDR
        && !i_rnd_wdata[spp_pkg::RELEASE_BIT];
    always_ff @(posedge i_ref_clk or negedge rst_ref_n) begin
        if (!rst_ref_n) begin
            release_tgl_q <= 1'b0;
        end else if (release_cmd) begin
            release_tgl_q <= !release_tgl_q;
        end
    end

    logic [2:0] rel_sync_q;
    logic release_pulse;
    always_ff @(posedge i_seq_clk or negedge rst_seq_n) begin
        if (!rst_seq_n) begin
            rel_sync_q <= 3'h0;
        end else begin
            rel_sync_q <= {rel_sync_q[1:0], release_tgl_q};
        end
    end
    assign release_pulse = rel_sync_q[2] ^ rel_sync_q[1];

    // stop mode: entered by the controller, left by the release command
    logic stopped_q;
    always_ff @(posedge i_seq_clk or negedge rst_seq_n) begin
        if (!rst_seq_n) begin
            stopped_q <= 1'b0;
        end else if (release_pulse) begin
            stopped_q <= 1'b0;
        end else if (i_stop) begin
            stopped_q <= 1'b1;
        end
    end
    assign o_stopped = stopped_q;

    // pointer
    logic [ADDR_W-1:0] ptr_q;
    logic load_hold_q;
    logic [DATA_W-1:0] mem_q [1 << ADDR_W];
    logic do_write;
    logic do_read;
    spp_pkg::spp_wr_t wr_word;

    assign do_write = !stopped_q && !i_sequential_chip_select_n
        && !i_sequential_read_write_select && o_wr_ready;
    assign do_read = !stopped_q && !i_sequential_chip_select_n
        && i_sequential_read_write_select;

    always_ff @(posedge i_seq_clk or negedge rst_seq_n) begin
        if (!rst_seq_n) begin
            ptr_q <= spp_pkg::PTR_RESET;
        end else if (stopped_q) begin
            ptr_q <= ptr_q;
        end else if (!i_start_pointer_strobe_one_n) begin
            ptr_q <= i_start_addr_one;
        end else if (!i_start_pointer_strobe_two_n) begin
            ptr_q <= i_start_addr_two;
        end else if (!i_pointer_load_strobe_n) begin
            ptr_q <= i_load_addr;
        end else if (load_hold_q) begin
            ptr_q <= ptr_q;
        end else if (!i_count_enable_n) begin
            ptr_q <= ptr_q + ADDR_W'(1);
        end
        // count enable high: hold, so a further write hits the same word
    end

    // only the load strobe suppresses the next increment
    always_ff @(posedge i_seq_clk or negedge rst_seq_n) begin
        if (!rst_seq_n) begin
            load_hold_q <= 1'b0;
        end else begin
            load_hold_q <= !stopped_q && i_start_pointer_strobe_one_n
                && i_start_pointer_strobe_two_n && !i_pointer_load_strobe_n;
        end
    end

    always_ff @(posedge i_seq_clk) begin
        if (do_write) begin
            mem_q[ptr_q] <= i_seq_data;
        end
    end

    // registered access type and read data
    spp_pkg::spp_acc_t acc_q;
    logic [DATA_W-1:0] rdata_q;
    always_ff @(posedge i_seq_clk or negedge rst_seq_n) begin
        if (!rst_seq_n) begin
            acc_q <= spp_pkg::SPP_ACC_WRITE;
        end else if (do_write) begin
            acc_q <= spp_pkg::SPP_ACC_WRITE;
        end else if (do_read) begin
            acc_q <= spp_pkg::SPP_ACC_READ;
        end
    end
    always_ff @(posedge i_seq_clk or negedge rst_seq_n) begin
        if (!rst_seq_n) begin
            rdata_q <= '0;
        end else if (do_read) begin
            rdata_q <= mem_q[ptr_q];
        end
    end

    // output enable pin is from the controller; resynchronised as a level
    logic [1:0] oe_sync_q;
    always_ff @(posedge i_seq_clk or negedge rst_seq_n) begin
        if (!rst_seq_n) begin
            oe_sync_q <= 2'h3;
        end else begin
            oe_sync_q <= {oe_sync_q[0], i_sequential_output_enable_n};
        end
    end
    assign o_seq_data = rdata_q;
    // write registered: outputs off whatever output enable says
    assign o_seq_data_oe = !oe_sync_q[1] && acc_q == spp_pkg::SPP_ACC_READ;

    // written words are mirrored to the reference domain through a buffer;
    // a full buffer stalls sequential writes rather than dropping them
    spp_pkg::spp_wr_t fifo_out;
    logic fifo_valid;
    logic xfer_ready;
    assign wr_word.addr = ptr_q;
    assign wr_word.data = i_seq_data;

    spp_fifo #(
        .WIDTH($bits(spp_pkg::spp_wr_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_seq_clk),
        .i_rst_n(rst_seq_n),
        .i_in_valid(do_write),
        .o_in_ready(o_wr_ready),
        .i_in_data(wr_word),
        .o_out_valid(fifo_valid),
        .i_out_ready(xfer_ready),
        .o_out_data(fifo_out)
    );

    // handshake crossing of one word at a time into the reference domain
    logic req_q;
    logic [spp_pkg::ADDR_W+spp_pkg::DATA_W-1:0] hold_q;
    logic [2:0] ack_sync_q;
    logic [2:0] req_sync_q;
    logic ack_q;
    logic busy_q;
    logic out_valid_q;
    assign xfer_ready = !busy_q;

    always_ff @(posedge i_seq_clk or negedge rst_seq_n) begin
        if (!rst_seq_n) begin
            busy_q <= 1'b0;
            req_q <= 1'b0;
            hold_q <= '0;
            ack_sync_q <= 3'h0;
        end else begin
            ack_sync_q <= {ack_sync_q[1:0], ack_q};
            if (!busy_q && fifo_valid) begin
                busy_q <= 1'b1;
                req_q <= !req_q;
                hold_q <= fifo_out;
            end else if (busy_q && ack_sync_q[1] == req_q) begin
                busy_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_ref_n) begin
        if (!rst_ref_n) begin
            req_sync_q <= 3'h0;
            ack_q <= 1'b0;
            out_valid_q <= 1'b0;
            o_rnd_wr_addr <= '0;
            o_rnd_wr_data <= '0;
        end else begin
            req_sync_q <= {req_sync_q[1:0], req_q};
            if (out_valid_q && i_rnd_wr_ready) begin
                out_valid_q <= 1'b0;
                ack_q <= req_sync_q[2];
            end else if (!out_valid_q && req_sync_q[2] != ack_q
                    && req_sync_q[2] == req_sync_q[1]) begin
                out_valid_q <= 1'b1;
                o_rnd_wr_addr <= hold_q[spp_pkg::ADDR_W+spp_pkg::DATA_W-1:spp_pkg::DATA_W];
                o_rnd_wr_data <= hold_q[spp_pkg::DATA_W-1:0];
            end
        end
    end
    assign o_rnd_wr_valid = out_valid_q;
endmodule : spp_top

// [verification/spp_props.sv]
/* spp_props: port checks for spp_top.
   Assumes both clock domains share i_reset_n. */
`timescale 1ns/10ps
module spp_props #(
    parameter int DATA_W = 8
) (
    input wire logic i_ref_clk,
    input wire logic i_seq_clk,
    input wire logic i_reset_n,
    input wire logic i_sequential_chip_select_n,
    input wire logic i_sequential_read_write_select,
    input wire logic i_sequential_output_enable_n,
    input wire logic i_stop,
    input wire logic i_cmd_select_n,
    input wire logic i_rnd_chip_enable_n,
    input wire logic i_rnd_write,
    input wire logic [2:0] i_rnd_addr,
    input wire logic [DATA_W-1:0] i_rnd_wdata,
    input wire logic [DATA_W-1:0] o_seq_data,
    input wire logic o_seq_data_oe,
    input wire logic o_stopped,
    input wire logic o_wr_ready
);
    wire logic sel = !i_sequential_chip_select_n && !o_stopped;
    wire logic rd = sel && i_sequential_read_write_select;
    wire logic wr = sel && !i_sequential_read_write_select && o_wr_ready;
    wire logic rel = !i_cmd_select_n && i_rnd_chip_enable_n && i_rnd_write
        && i_rnd_addr == spp_pkg::CMD_RELEASE_ADDR && !i_rnd_wdata[spp_pkg::RELEASE_BIT];
    oe_idle_off_a: assert property (@(posedge i_seq_clk) disable iff (!i_reset_n)
        i_sequential_output_enable_n [*5] |-> !o_seq_data_oe) else $error("oe on");
    oe_cause_a: assert property (@(posedge i_seq_clk) disable iff (!i_reset_n)
        $rose(o_seq_data_oe) |-> !$past(i_sequential_output_enable_n, 2)) else $error("oe rose");
    read_oe_a: assert property (@(posedge i_seq_clk) disable iff (!i_reset_n)
        (!i_sequential_output_enable_n) [*5] ##0 rd |-> ##[1:2] o_seq_data_oe)
        else $error("read oe off");
    write_oe_a: assert property (@(posedge i_seq_clk) disable iff (!i_reset_n)
        wr ##1 !rd |=> !o_seq_data_oe) else $error("write oe on");
    write_hold_a: assert property (@(posedge i_seq_clk) disable iff (!i_reset_n)
        wr ##1 (!rd) [*4] |=> !o_seq_data_oe) else $error("oe back");
    data_cause_a: assert property (@(posedge i_seq_clk) disable iff (!i_reset_n)
        $changed(o_seq_data) |-> $past(rd)) else $error("data moved");
    stop_entry_a: assert property (@(posedge i_seq_clk) disable iff (!i_reset_n)
        i_stop && !o_stopped |-> ##[1:2] o_stopped) else $error("no stop");
    release_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        rel && o_stopped |-> ##[1:20] !o_stopped) else $error("no release");
    cover property (@(posedge i_seq_clk) rd ##1 o_seq_data_oe);
    cover property (@(posedge i_seq_clk) $rose(o_stopped));
    cover property (@(posedge i_ref_clk) rel && o_stopped);
endmodule : spp_props

bind spp_top spp_props #(.DATA_W(DATA_W)) props (
    .i_ref_clk, .i_seq_clk, .i_reset_n, .i_sequential_chip_select_n,
    .i_sequential_read_write_select, .i_sequential_output_enable_n, .i_stop,
    .i_cmd_select_n, .i_rnd_chip_enable_n, .i_rnd_write, .i_rnd_addr, .i_rnd_wdata,
    .o_seq_data, .o_seq_data_oe, .o_stopped, .o_wr_ready
);

// [verification/spp_sink_model.sv]
/* spp_sink_model: ref-side taker of write mirror words.
   Assumes the word holds while valid waits for ready. */
`timescale 1ns/10ps
module spp_sink_model (
    input wire logic i_clk,
    input wire logic i_stall,
    input wire logic i_valid,
    input wire spp_pkg::spp_wr_t i_word,
    output logic o_ready
);
    spp_pkg::spp_wr_t got[$];
    assign o_ready = !i_stall;
    always @(posedge i_clk) begin
        if (i_valid && o_ready) begin
            got.push_back(i_word);
        end
    end
endmodule : spp_sink_model

// [verification/testbench.sv]
/* testbench: directed scenarios for spp_top.
   Assumes spp_props is bound and the sink model logs mirror words. */
`timescale 1ns/10ps
module testbench;
    localparam logic [6:0] IDL = 7'h7e, WRC = 7'h70, WRH = 7'h78, RDH = 7'h7a, RDC = 7'h72;
    localparam logic [6:0] LDP = 7'h6c, ST1 = 7'h3c, ST2 = 7'h5c, STP = 7'h7d;
    logic rclk = 1'b0, sclk = 1'b0, rst_n = 1'b0, oe_n = 1'b1, stall = 1'b0;
    logic s1_n = 1'b1, s2_n = 1'b1, ld_n = 1'b1, cen_n = 1'b1, cs_n = 1'b1, rw = 1'b1;
    logic stp = 1'b0, cmd_n = 1'b1, ce_n = 1'b1, rwr = 1'b0, oe, stopped, wr_rdy, mv, mr;
    logic [2:0] ra = 3'h0;
    logic [7:0] wd = 8'h00, rwd = 8'h00, rd;
    logic [10:0] a1 = 11'h123, a2 = 11'h7ff, la = 11'h055;
    spp_pkg::spp_wr_t mw, w;
    int errors = 0, num_checks = 0;
    initial forever #12.5 rclk = ~rclk;
    initial begin
        #7;
        forever #32 sclk = ~sclk;
    end
    spp_top dut (
        .i_ref_clk(rclk), .i_reset_n(rst_n), .i_seq_clk(sclk), .i_start_addr_one(a1),
        .i_start_addr_two(a2), .i_load_addr(la), .i_start_pointer_strobe_one_n(s1_n),
        .i_start_pointer_strobe_two_n(s2_n), .i_pointer_load_strobe_n(ld_n),
        .i_count_enable_n(cen_n), .i_sequential_chip_select_n(cs_n),
        .i_sequential_read_write_select(rw), .i_sequential_output_enable_n(oe_n),
        .i_stop(stp), .i_seq_data(wd), .o_seq_data(rd), .o_seq_data_oe(oe),
        .o_stopped(stopped), .i_cmd_select_n(cmd_n), .i_rnd_chip_enable_n(ce_n),
        .i_rnd_write(rwr), .i_rnd_addr(ra), .i_rnd_wdata(rwd), .o_wr_ready(wr_rdy),
        .o_rnd_wr_valid(mv), .i_rnd_wr_ready(mr), .o_rnd_wr_addr(mw.addr),
        .o_rnd_wr_data(mw.data)
    );
    spp_sink_model sink (.i_clk(rclk), .i_stall(stall), .i_valid(mv), .i_word(mw), .o_ready(mr));
    task automatic chk(string n, logic [18:0] e, logic [18:0] s);
        num_checks++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic drv(logic [6:0] c, logic [7:0] d = 8'h00);
        @(negedge sclk);
        {s1_n, s2_n, ld_n, cen_n, cs_n, rw, stp} = c;
        wd = d;
    endtask : drv
    task automatic expw(logic [10:0] a, logic [7:0] d);
        w = 'x;
        for (int i = 0; i < 100 && sink.got.size() == 0; i++) @(posedge rclk);
        if (sink.got.size() != 0) w = sink.got.pop_front();
        chk("mirror word", {a, d}, w);
    endtask : expw
    // one-cycle command write, then time for the crossing to settle
    task automatic rnd(logic c, logic [2:0] a, logic [7:0] d);
        @(negedge rclk);
        {cmd_n, ce_n, rwr, ra, rwd} = {1'b0, c, 1'b1, a, d};
        @(negedge rclk);
        {cmd_n, ce_n, rwr} = 3'b110;
        repeat (20) @(negedge rclk);
    endtask : rnd
    task automatic t_start();
        drv(ST1);
        drv(WRC, 8'h11);
        drv(WRC, 8'h22);
        drv(ST2);
        drv(WRC, 8'h33);
        drv(WRC, 8'h44);
        drv(IDL);
        expw(11'h123, 8'h11);
        expw(11'h124, 8'h22);
        expw(11'h7ff, 8'h33);
        expw(11'h000, 8'h44);
    endtask : t_start
    task automatic t_load();
        @(negedge sclk);
        oe_n = 1'b0;
        drv(LDP);
        drv(WRC, 8'h5a);
        drv(WRC, 8'ha5);
        drv(WRH, 8'h3c);
        drv(WRH, 8'hc3);
        drv(IDL);
        expw(11'h055, 8'h5a);
        expw(11'h055, 8'ha5);
        expw(11'h056, 8'h3c);
        expw(11'h056, 8'hc3);
    endtask : t_load
    task automatic t_read();
        drv(LDP);
        drv(RDC);
        drv(RDC);
        drv(WRH, 8'h99);
        chk("read data", 8'ha5, rd);
        chk("oe", 1'b1, oe);
        drv(IDL);
        drv(RDH);
        chk("oe", 1'b0, oe);
        drv(IDL);
        drv(WRC, 8'h66);
        drv(IDL);
        chk("read data", 8'h99, rd);
        expw(11'h056, 8'h99);
        expw(11'h056, 8'h66);
    endtask : t_read
    task automatic t_stop();
        drv(STP);
        drv(WRC, 8'h77);
        drv(IDL);
        chk("stopped", 1'b1, stopped);
        rnd(1'b0, 3'h4, 8'h00);
        rnd(1'b1, 3'h4, 8'h10);
        rnd(1'b1, 3'h3, 8'h00);
        chk("stopped", 1'b1, stopped);
        rnd(1'b1, 3'h4, 8'hef);
        chk("stopped", 1'b0, stopped);
        chk("mirror count", 19'h0, 19'(sink.got.size()));
        drv(WRC, 8'h88);
        drv(IDL);
        expw(11'h057, 8'h88);
    endtask : t_stop
    task automatic t_fill();
        int n;
        logic full;
        n = 0;
        full = 1'b0;
        @(negedge rclk);
        stall = 1'b1;
        // writes only while ready, so a refused one never moves the pointer
        repeat (16) begin
            @(negedge sclk);
            full |= !wr_rdy;
            {cen_n, cs_n, rw, wd} = {!wr_rdy, !wr_rdy, 1'b0, n[7:0]};
            n += wr_rdy;
        end
        drv(IDL);
        chk("buffer full", 1'b1, full);
        @(negedge rclk);
        stall = 1'b0;
        for (int i = 0; i < n; i++) expw(11'h058 + i[10:0], i[7:0]);
    endtask : t_fill
    task results();
        if (errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results
    initial begin
        repeat (3) @(posedge rclk);
        @(negedge rclk);
        rst_n = 1'b1;
        repeat (4) @(posedge sclk);
        t_start();
        t_load();
        t_read();
        t_stop();
        t_fill();
        results();
    end
    initial begin
        #200000;
        errors++;
        results();
    end
endmodule : testbench
